// >>> tccpo_pkg.sv
// Package with register map, field layouts, reset values and carriers
package tccpo_pkg;
  // Register byte offsets on the Avalon-MM slave
  localparam logic [5:0] OFS_CTRL       = 6'h00;
  localparam logic [5:0] OFS_COUNTER    = 6'h04;
  localparam logic [5:0] OFS_GEN_A      = 6'h08;
  localparam logic [5:0] OFS_GEN_B      = 6'h0c;
  localparam logic [5:0] OFS_GEN_D      = 6'h10;
  localparam logic [5:0] OFS_PULSE_MODE = 6'h14;
  localparam logic [5:0] OFS_PULSE_DATA = 6'h18;
  localparam logic [5:0] OFS_STATUS     = 6'h1c;
  localparam logic [5:0] OFS_MASK       = 6'h20;
  localparam logic [5:0] OFS_PINS       = 6'h24;

  // Pulse mode register field positions and reset value
  localparam int unsigned PM_G1_POL = 5;
  localparam int unsigned PM_G0_POL = 4;
  localparam int unsigned PM_G3_NOV = 3;
  localparam int unsigned PM_G2_NOV = 2;
  localparam logic [5:0] PULSE_MODE_RST = 6'h30;

  // Status and mask bit positions
  localparam int unsigned ST_EVT_D = 0;
  localparam int unsigned ST_CMP_A = 1;
  localparam int unsigned ST_CMP_B = 2;
  localparam int unsigned ST_OVF   = 3;
  localparam int unsigned ST_UNF   = 4;
  localparam int unsigned ST_CAP_A = 5;
  localparam int unsigned ST_W     = 6;

  // Counter end values and the undivided prescaler code
  localparam logic [15:0] CNT_MAX   = 16'hffff;
  localparam logic [15:0] CNT_MIN   = 16'h0000;
  localparam logic [2:0]  PSC_UNDIV = 3'h0;

  // Control register layout, io field in the low four bits
  typedef struct packed {
    logic       a_capture;      // General register A captures on pin A
    logic       clear_on_a;     // Counter cleared at compare match A
    logic       count_down;     // Counter direction
    logic       run;            // Counter runs
    logic       buffer_mode_b;  // Register D buffers register B
    logic [3:0] reg_d_io_ctrl;  // Bits 3..0 of the register D io field
  } tccpo_ctrl_t;

  localparam tccpo_ctrl_t CTRL_RST = '0;

  // One-cycle timer events handed to the pulse generator
  typedef struct packed {
    logic cmp_a;
    logic cmp_b;
    logic cap_a;
  } tccpo_evt_t;
endpackage : tccpo_pkg

// >>> tccpo_top.sv
// Timer channel compare/capture on register D plus pulse output generator
`timescale 1ns/100ps
module tccpo_top (
  input  wire logic        clk,                     // 100 MHz system clock
  input  wire logic        sys_rst,                 // Sync reset, active high
  input  wire logic [5:0]  avs_address,             // Byte address
  input  wire logic        avs_read,                // Read request
  input  wire logic        avs_write,               // Write request
  input  wire logic [31:0] avs_writedata,           // Write data
  output logic      [31:0] avs_readdata,            // Read data
  output logic             avs_waitrequest,         // Stall until answer
  input  wire logic        cap_d_in,                // Register D pin input
  input  wire logic        cap_a_in,                // Register A pin input
  input  wire logic        neighbour_count_pulse,   // Neighbour counted
  input  wire logic [2:0]  neighbour_prescale_sel,  // Neighbour prescale
  input  wire logic        neighbour_undivided,     // Neighbour on clk/1
  output logic             cmp_d_out,               // Compare pin level
  output logic             cmp_d_oe,                // Compare pin driven
  output logic      [15:0] pulse_out,               // Pulse output pins
  output logic             irq                      // Level interrupt
);

  tccpo_pkg::tccpo_ctrl_t ctrl_reg;
  tccpo_pkg::tccpo_evt_t  evt_reg;
  logic [15:0]            timer_counter_value_reg;
  logic [15:0]            general_reg_a_reg;
  logic [15:0]            general_reg_b_reg;
  logic [15:0]            chan3_general_reg_d_reg;
  logic [5:0]             pulse_mode_reg;
  logic [15:0]            pulse_data_reg;
  logic [5:0]             status_reg;
  logic [5:0]             mask_reg;
  logic                   cap_d_prev_reg;
  logic                   cap_a_prev_reg;
  logic                   wr_en;
  logic                   match_a;
  logic                   match_b;
  logic                   match_d;
  logic                   cnt_clear;
  logic                   ovf_evt;
  logic                   unf_evt;
  logic                   cap_d_evt;
  logic                   cmp_d_evt;
  logic                   cap_a_evt;
  logic                   d_capture_mode;
  logic                   d_compare_mode;
  logic [5:0]             events;
  logic [15:0]            pulse_target;
  logic [31:0]            read_next;
  logic                   trig_a;

  // Replace the pins selected by sel with the target levels
  function automatic logic [3:0] merge4(input logic [3:0] cur,
                                        input logic [3:0] tgt,
                                        input logic [3:0] sel);
    merge4 = (cur & ~sel) | (tgt & sel);
  endfunction : merge4

  // One word is taken per answer; waitrequest drops for that cycle only
  assign wr_en = avs_write && !avs_waitrequest;

  // Register D role decode; buffer mode removes both roles
  assign d_capture_mode = ctrl_reg.reg_d_io_ctrl[3]
                          && !ctrl_reg.buffer_mode_b;
  assign d_compare_mode = !ctrl_reg.reg_d_io_ctrl[3]
                          && (ctrl_reg.reg_d_io_ctrl[1:0] != 2'h0)
                          && !ctrl_reg.buffer_mode_b;

  // Compare matches against the live counter value
  assign match_a = ctrl_reg.run && !ctrl_reg.a_capture
                   && (timer_counter_value_reg == general_reg_a_reg);
  assign match_b = ctrl_reg.run
                   && (timer_counter_value_reg == general_reg_b_reg);
  assign match_d = ctrl_reg.run
                   && (timer_counter_value_reg == chan3_general_reg_d_reg);
  assign cmp_d_evt = match_d && d_compare_mode;

  // Counter clear and end-of-range detection; clear suppresses the flags
  assign cnt_clear = ctrl_reg.clear_on_a && match_a;
  assign ovf_evt   = ctrl_reg.run && !ctrl_reg.count_down && !cnt_clear
                     && (timer_counter_value_reg == tccpo_pkg::CNT_MAX);
  assign unf_evt   = ctrl_reg.run && ctrl_reg.count_down && !cnt_clear
                     && (timer_counter_value_reg == tccpo_pkg::CNT_MIN);

  // Capture sources for register D
  always_comb
  begin
    cap_d_evt = 1'b0;
    if (d_capture_mode)
    begin
      if (ctrl_reg.reg_d_io_ctrl[2])
        cap_d_evt = neighbour_count_pulse
                    && !(neighbour_prescale_sel == tccpo_pkg::PSC_UNDIV
                         && neighbour_undivided);
      else if (ctrl_reg.reg_d_io_ctrl[1])
        cap_d_evt = cap_d_in != cap_d_prev_reg;
      else if (ctrl_reg.reg_d_io_ctrl[0])
        cap_d_evt = cap_d_prev_reg && !cap_d_in;
      else
        cap_d_evt = !cap_d_prev_reg && cap_d_in;
    end
  end

  // Register A captures on a rising edge of its pin
  assign cap_a_evt = ctrl_reg.a_capture && !cap_a_prev_reg && cap_a_in;

  // Previous pin levels for edge detection
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      cap_d_prev_reg <= 1'b0;
      cap_a_prev_reg <= 1'b0;
    end
    else
    begin
      cap_d_prev_reg <= cap_d_in;
      cap_a_prev_reg <= cap_a_in;
    end
  end

  // Control register; a write also reloads the compare pin below
  always_ff @(posedge clk)
  begin
    if (sys_rst)
      ctrl_reg <= tccpo_pkg::CTRL_RST;
    else if (wr_en && avs_address == tccpo_pkg::OFS_CTRL)
      ctrl_reg <= tccpo_pkg::tccpo_ctrl_t'(avs_writedata[8:0]);
  end

  // Counter: software write first, then clear, then count
  always_ff @(posedge clk)
  begin
    if (sys_rst)
      timer_counter_value_reg <= 16'h0000;
    else if (wr_en && avs_address == tccpo_pkg::OFS_COUNTER)
      timer_counter_value_reg <= avs_writedata[15:0];
    else if (cnt_clear)
      timer_counter_value_reg <= 16'h0000;
    else if (ctrl_reg.run && ctrl_reg.count_down)
      timer_counter_value_reg <= timer_counter_value_reg - 16'h0001;
    else if (ctrl_reg.run)
      timer_counter_value_reg <= timer_counter_value_reg + 16'h0001;
  end

  // General registers A and B; B reloads from D in buffer mode
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      general_reg_a_reg <= 16'hffff;
      general_reg_b_reg <= 16'hffff;
    end
    else
    begin
      if (cap_a_evt)
        general_reg_a_reg <= timer_counter_value_reg;
      else if (wr_en && avs_address == tccpo_pkg::OFS_GEN_A)
        general_reg_a_reg <= avs_writedata[15:0];
      if (match_b && ctrl_reg.buffer_mode_b)
        general_reg_b_reg <= chan3_general_reg_d_reg;
      else if (wr_en && avs_address == tccpo_pkg::OFS_GEN_B)
        general_reg_b_reg <= avs_writedata[15:0];
    end
  end

  // Register D; a capture wins over a software write in the same cycle
  always_ff @(posedge clk)
  begin
    if (sys_rst)
      chan3_general_reg_d_reg <= 16'hffff;
    else if (cap_d_evt)
      chan3_general_reg_d_reg <= timer_counter_value_reg;
    else if (wr_en && avs_address == tccpo_pkg::OFS_GEN_D)
      chan3_general_reg_d_reg <= avs_writedata[15:0];
  end

  // Compare pin: initial level on control write, then match actions
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      cmp_d_out <= 1'b0;
      cmp_d_oe  <= 1'b0;
    end
    else if (wr_en && avs_address == tccpo_pkg::OFS_CTRL)
    begin
      cmp_d_out <= avs_writedata[2];
      cmp_d_oe  <= !avs_writedata[3] && !avs_writedata[4]
                   && (avs_writedata[1:0] != 2'h0);
    end
    else if (cmp_d_evt)
    begin
      unique case (ctrl_reg.reg_d_io_ctrl[1:0])
        2'h1:    cmp_d_out <= 1'b0;
        2'h2:    cmp_d_out <= 1'b1;
        default: cmp_d_out <= !cmp_d_out;
      endcase
    end
    else
      cmp_d_oe <= d_compare_mode;
  end

  // Registered single-cycle strobes for the pulse generator
  always_ff @(posedge clk)
  begin
    if (sys_rst)
      evt_reg <= '0;
    else
    begin
      evt_reg.cmp_a <= match_a;
      evt_reg.cmp_b <= match_b;
      evt_reg.cap_a <= cap_a_evt;
    end
  end

  // Pulse mode and next-data registers
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      pulse_mode_reg <= tccpo_pkg::PULSE_MODE_RST;
      pulse_data_reg <= 16'h0000;
    end
    else
    begin
      if (wr_en && avs_address == tccpo_pkg::OFS_PULSE_MODE)
        pulse_mode_reg <= avs_writedata[5:0];
      if (wr_en && avs_address == tccpo_pkg::OFS_PULSE_DATA)
        pulse_data_reg <= avs_writedata[15:0];
    end
  end

  // Pin levels wanted; groups 1 and 0 invert when their bit is 0
  assign pulse_target = {pulse_data_reg[15:8],
    pulse_data_reg[7:4] ^ {4{!pulse_mode_reg[tccpo_pkg::PM_G1_POL]}},
    pulse_data_reg[3:0] ^ {4{!pulse_mode_reg[tccpo_pkg::PM_G0_POL]}}};

  // Trigger of A comes from capture when register A captures
  assign trig_a = ctrl_reg.a_capture ? evt_reg.cap_a
                                     : evt_reg.cmp_a;

  // Pulse pins; non-overlap groups take zeros at A and ones at B
  always_ff @(posedge clk)
  begin
    if (sys_rst)
      pulse_out <= 16'h0000;
    else
    begin
      if (trig_a)
        pulse_out[7:0] <= pulse_target[7:0];
      if (pulse_mode_reg[tccpo_pkg::PM_G2_NOV])
        pulse_out[11:8] <= merge4(pulse_out[11:8], pulse_target[11:8],
          ({4{trig_a}} & ~pulse_target[11:8])
          | ({4{evt_reg.cmp_b}} & pulse_target[11:8]));
      else if (trig_a)
        pulse_out[11:8] <= pulse_target[11:8];
      if (pulse_mode_reg[tccpo_pkg::PM_G3_NOV])
        pulse_out[15:12] <= merge4(pulse_out[15:12], pulse_target[15:12],
          ({4{trig_a}} & ~pulse_target[15:12])
          | ({4{evt_reg.cmp_b}} & pulse_target[15:12]));
      else if (trig_a)
        pulse_out[15:12] <= pulse_target[15:12];
    end
  end

  // Status events in package bit order
  assign events = {cap_a_evt, unf_evt, ovf_evt, match_b, match_a,
                   cap_d_evt | cmp_d_evt};

  // Sticky status, write one to clear; a new event wins over the clear
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      status_reg <= 6'h00;
      mask_reg   <= 6'h00;
    end
    else
    begin
      if (wr_en && avs_address == tccpo_pkg::OFS_STATUS)
        status_reg <= (status_reg & ~avs_writedata[5:0]) | events;
      else
        status_reg <= status_reg | events;
      if (wr_en && avs_address == tccpo_pkg::OFS_MASK)
        mask_reg <= avs_writedata[5:0];
    end
  end

  // Interrupt from flop; follows status by one cycle
  always_ff @(posedge clk)
  begin
    if (sys_rst)
      irq <= 1'b0;
    else
      irq <= |(status_reg & mask_reg);
  end

  // Read mux; unmapped offsets read as zero
  always_comb
  begin
    read_next = 32'h0000_0000;
    unique case (avs_address)
      tccpo_pkg::OFS_CTRL:       read_next[8:0]  = ctrl_reg;
      tccpo_pkg::OFS_COUNTER:    read_next[15:0] = timer_counter_value_reg;
      tccpo_pkg::OFS_GEN_A:      read_next[15:0] = general_reg_a_reg;
      tccpo_pkg::OFS_GEN_B:      read_next[15:0] = general_reg_b_reg;
      tccpo_pkg::OFS_GEN_D:      read_next[15:0] = chan3_general_reg_d_reg;
      tccpo_pkg::OFS_PULSE_MODE: read_next[5:0]  = pulse_mode_reg;
      tccpo_pkg::OFS_PULSE_DATA: read_next[15:0] = pulse_data_reg;
      tccpo_pkg::OFS_STATUS:     read_next[5:0]  = status_reg;
      tccpo_pkg::OFS_MASK:       read_next[5:0]  = mask_reg;
      tccpo_pkg::OFS_PINS:       read_next[17:0] = {cmp_d_oe, cmp_d_out,
                                                    pulse_out};
      default:                   read_next = 32'h0000_0000;
    endcase
  end

  // Bus answer one edge after a request appears, then back to waiting
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      avs_waitrequest <= 1'b1;
      avs_readdata    <= 32'h0000_0000;
    end
    else if ((avs_read || avs_write) && avs_waitrequest)
    begin
      avs_waitrequest <= 1'b0;
      avs_readdata    <= read_next;
    end
    else
      avs_waitrequest <= 1'b1;
  end

endmodule : tccpo_top

// >>> tccpo_properties.sv
// Checker for bus handshake, compare pin and interrupt behaviour
`timescale 1ns/100ps
module tccpo_properties (
  input wire logic        clk,             // System clock
  input wire logic        sys_rst,         // Sync reset
  input wire logic [5:0]  avs_address,     // Byte address
  input wire logic        avs_read,        // Read request
  input wire logic        avs_write,       // Write request
  input wire logic [31:0] avs_writedata,   // Write data
  input wire logic [31:0] avs_readdata,    // Read data
  input wire logic        avs_waitrequest, // Stall
  input wire logic        cmp_d_out,       // Compare pin level
  input wire logic        cmp_d_oe,        // Compare pin driven
  input wire logic        irq              // Level interrupt
);
  logic wr_done;  // A write lands at this edge
  logic ctrl_wr;  // A control write lands at this edge
  // Decoded strobes keep the properties short
  assign wr_done = avs_write && !avs_waitrequest;
  assign ctrl_wr = wr_done && avs_address == tccpo_pkg::OFS_CTRL;
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  a_wait_answers: assert property ((avs_read || avs_write) && avs_waitrequest
    |=> !avs_waitrequest) else $error("request not answered next cycle");
  a_wait_single: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low for more than one cycle");
  a_read_upper: assert property (!avs_waitrequest
    |-> avs_readdata[31:18] == 14'h0) else $error("upper read bits set");
  a_unmapped_zero: assert property (avs_read && avs_waitrequest
    && avs_address > 6'h24 |=> avs_readdata == 32'h0)
    else $error("unmapped read not zero");
  a_cmp_init_level: assert property (
    ctrl_wr && !avs_writedata[3] |=> cmp_d_out == $past(avs_writedata[2]))
    else $error("initial compare level wrong");
  a_oe_buffer_off: assert property (
    ctrl_wr && avs_writedata[4] |=> !cmp_d_oe)
    else $error("compare pin driven in buffer mode");
  a_oe_capture_off: assert property (
    ctrl_wr && avs_writedata[3] |=> !cmp_d_oe)
    else $error("compare pin driven in capture mode");
  a_oe_write_only: assert property (
    $changed(cmp_d_oe) |-> $past(ctrl_wr))
    else $error("compare enable moved without control write");
  a_pin_moves_driven: assert property (
    $changed(cmp_d_out) && !$past(ctrl_wr) |-> cmp_d_oe)
    else $error("compare level moved while undriven");
  a_irq_fall_cause: assert property ($fell(irq)
    |-> $past(wr_done, 1) || $past(wr_done, 2) || $past(wr_done, 3))
    else $error("interrupt dropped without a write");
  // Main scenarios reached
  c_toggle_mode: cover property (ctrl_wr && avs_writedata[3:0] == 4'h3);
  c_irq_raised: cover property ($rose(irq));
  c_pin_match: cover property ($changed(cmp_d_out) && cmp_d_oe);
endmodule : tccpo_properties

bind tccpo_top tccpo_properties u_props (
  .clk(clk), .sys_rst(sys_rst), .avs_address(avs_address),
  .avs_read(avs_read), .avs_write(avs_write),
  .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
  .avs_waitrequest(avs_waitrequest), .cmp_d_out(cmp_d_out),
  .cmp_d_oe(cmp_d_oe), .irq(irq));

// >>> tb.sv
// Self-checking testbench for the timer compare/capture and pulse block
`timescale 1ns/100ps
module tb;
  logic        clk, sys_rst, avs_read, avs_write, avs_waitrequest;
  logic [5:0]  avs_address;
  logic [31:0] avs_writedata, avs_readdata, q;
  logic        cap_d_in, cap_a_in, neighbour_count_pulse;
  logic [2:0]  neighbour_prescale_sel;
  logic        neighbour_undivided, cmp_d_out, cmp_d_oe, irq;
  logic [15:0] pulse_out;
  int          n_mismatch, checked;

  tccpo_top u_dut (
    .clk(clk), .sys_rst(sys_rst), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .cap_d_in(cap_d_in),
    .cap_a_in(cap_a_in), .neighbour_count_pulse(neighbour_count_pulse),
    .neighbour_prescale_sel(neighbour_prescale_sel),
    .neighbour_undivided(neighbour_undivided), .cmp_d_out(cmp_d_out),
    .cmp_d_oe(cmp_d_oe), .pulse_out(pulse_out), .irq(irq));

  // 100 MHz clock
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task tally_and_finish;
    if (n_mismatch == 0 && checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : tally_and_finish

  task chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // One Avalon access; request held until waitrequest is sampled low
  task bus(input logic wr, input logic [5:0] a, input logic [31:0] d);
    @(posedge clk);
    avs_write <= wr;
    avs_read <= !wr;
    avs_address <= a;
    avs_writedata <= d;
    // No cycle count assumed; a slave that never answers meets the watchdog
    do
    begin
      @(posedge clk);
    end
    while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask : bus

  task rdc(input logic [5:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    chk(q, exp);
  endtask : rdc

  task t_reset_vals;
    rdc(tccpo_pkg::OFS_PULSE_MODE, 32'h30);
    rdc(tccpo_pkg::OFS_GEN_D, 32'hffff);
    bus(1'b1, 6'h3c, 32'hffff);
    rdc(6'h3c, 32'h0);
    rdc(tccpo_pkg::OFS_PINS, 32'h0);
  endtask : t_reset_vals

  // Every compare code; the counter passes register D once per pass
  task t_compare;
    logic e;
    for (int i = 0; i < 8; i++)
    begin
      bus(1'b1, tccpo_pkg::OFS_CTRL, 32'(i));
      @(negedge clk);
      chk(32'(cmp_d_out), 32'(i[2]));
      bus(1'b1, tccpo_pkg::OFS_COUNTER, 32'h0);
      bus(1'b1, tccpo_pkg::OFS_GEN_D, 32'h10);
      bus(1'b1, tccpo_pkg::OFS_CTRL, 32'(i) | 32'h20);
      repeat (40) @(posedge clk);
      e = (i[1:0] == 2'h1) ? 1'b0 : (i[1:0] == 2'h2) ? 1'b1 : !i[2];
      chk(32'(cmp_d_oe), 32'(i[1:0] != 2'h0));
      if (i[1:0] != 2'h0)
        chk(32'(cmp_d_out), 32'(e));
    end
    bus(1'b1, tccpo_pkg::OFS_CTRL, 32'h32);
    @(negedge clk);
    chk(32'(cmp_d_oe), 32'h0);
  endtask : t_compare

  // Counter held still so a capture shows its exact value
  task try_cap(input logic [31:0] c, input logic lvl, input logic nb,
               input logic hit);
    logic [31:0] v;
    v = 32'h0a00 | c;
    bus(1'b1, tccpo_pkg::OFS_GEN_D, 32'h1234);
    bus(1'b1, tccpo_pkg::OFS_COUNTER, v);
    bus(1'b1, tccpo_pkg::OFS_CTRL, c);
    @(posedge clk);
    if (nb)
      neighbour_count_pulse <= 1'b1;
    else
      cap_d_in <= lvl;
    @(posedge clk);
    neighbour_count_pulse <= 1'b0;
    repeat (3) @(posedge clk);
    rdc(tccpo_pkg::OFS_GEN_D, hit ? v : 32'h1234);
  endtask : try_cap

  task t_capture;
    // Stop the counter left running by the compare scenario
    bus(1'b1, tccpo_pkg::OFS_CTRL, 32'h0);
    try_cap(32'h8, 1'b1, 1'b0, 1'b1);
    try_cap(32'h8, 1'b0, 1'b0, 1'b0);
    try_cap(32'h9, 1'b1, 1'b0, 1'b0);
    try_cap(32'h9, 1'b0, 1'b0, 1'b1);
    try_cap(32'ha, 1'b1, 1'b0, 1'b1);
    try_cap(32'hb, 1'b0, 1'b0, 1'b1);
    try_cap(32'hc, 1'b0, 1'b1, 1'b1);
    neighbour_undivided <= 1'b1;
    try_cap(32'hf, 1'b0, 1'b1, 1'b0);
    neighbour_prescale_sel <= 3'h2;
    try_cap(32'hd, 1'b0, 1'b1, 1'b1);
    try_cap(32'h18, 1'b1, 1'b0, 1'b0);
  endtask : t_capture

  // Wrap with a clear at match A versus a plain wrap, plus interrupt path
  task t_overflow;
    bus(1'b1, tccpo_pkg::OFS_STATUS, 32'h7f);
    bus(1'b1, tccpo_pkg::OFS_MASK, 32'h0);
    bus(1'b1, tccpo_pkg::OFS_GEN_A, 32'hffff);
    bus(1'b1, tccpo_pkg::OFS_COUNTER, 32'hfff0);
    bus(1'b1, tccpo_pkg::OFS_CTRL, 32'ha0);
    repeat (40) @(posedge clk);
    bus(1'b0, tccpo_pkg::OFS_STATUS, 32'h0);
    chk(32'(q[3:1]), 32'h3);
    bus(1'b1, tccpo_pkg::OFS_CTRL, 32'h20);
    bus(1'b1, tccpo_pkg::OFS_COUNTER, 32'hfff0);
    repeat (40) @(posedge clk);
    bus(1'b0, tccpo_pkg::OFS_STATUS, 32'h0);
    chk(32'(q[3]), 32'h1);
    chk(32'(irq), 32'h0);
    bus(1'b1, tccpo_pkg::OFS_MASK, 32'h8);
    repeat (2) @(posedge clk);
    chk(32'(irq), 32'h1);
    bus(1'b1, tccpo_pkg::OFS_STATUS, 32'h8);
    repeat (2) @(posedge clk);
    chk(32'(irq), 32'h0);
  endtask : t_overflow

  // Down-count to zero with a clear at match A, then a plain underflow
  task t_underflow;
    bus(1'b1, tccpo_pkg::OFS_CTRL, 32'h0);
    bus(1'b1, tccpo_pkg::OFS_STATUS, 32'h7f);
    bus(1'b1, tccpo_pkg::OFS_GEN_A, 32'h0);
    bus(1'b1, tccpo_pkg::OFS_COUNTER, 32'h10);
    bus(1'b1, tccpo_pkg::OFS_CTRL, 32'he0);
    repeat (40) @(posedge clk);
    bus(1'b0, tccpo_pkg::OFS_STATUS, 32'h0);
    chk(32'(q[4]), 32'h0);
    chk(32'(q[1]), 32'h1);
    rdc(tccpo_pkg::OFS_COUNTER, 32'h0);
    bus(1'b1, tccpo_pkg::OFS_CTRL, 32'h60);
    repeat (4) @(posedge clk);
    bus(1'b0, tccpo_pkg::OFS_STATUS, 32'h0);
    chk(32'(q[4]), 32'h1);
    // Pulse scenario expects the counter running upwards
    bus(1'b1, tccpo_pkg::OFS_CTRL, 32'h20);
  endtask : t_underflow

  // Match B at 0x60 after each counter restart, match A at 0x20 while register A does not capture
  task t_pulse;
    bus(1'b1, tccpo_pkg::OFS_GEN_A, 32'h20);
    bus(1'b1, tccpo_pkg::OFS_GEN_B, 32'h60);
    bus(1'b1, tccpo_pkg::OFS_PULSE_DATA, 32'h5a3c);
    bus(1'b1, tccpo_pkg::OFS_COUNTER, 32'h0);
    repeat (128) @(posedge clk);
    chk(32'(pulse_out), 32'h5a3c);
    bus(1'b1, tccpo_pkg::OFS_PULSE_MODE, 32'h0);
    bus(1'b1, tccpo_pkg::OFS_PULSE_DATA, 32'h3cc3);
    bus(1'b1, tccpo_pkg::OFS_COUNTER, 32'h0);
    repeat (128) @(posedge clk);
    chk(32'(pulse_out), 32'h3c3c);
    bus(1'b1, tccpo_pkg::OFS_PULSE_MODE, 32'h3c);
    bus(1'b1, tccpo_pkg::OFS_PULSE_DATA, 32'hc3a5);
    bus(1'b1, tccpo_pkg::OFS_COUNTER, 32'h0);
    repeat (64) @(posedge clk);
    chk(32'(pulse_out), 32'h00a5);
    repeat (64) @(posedge clk);
    chk(32'(pulse_out), 32'hc3a5);
    bus(1'b1, tccpo_pkg::OFS_PULSE_MODE, 32'h30);
    bus(1'b1, tccpo_pkg::OFS_PULSE_DATA, 32'h1111);
    bus(1'b1, tccpo_pkg::OFS_CTRL, 32'h120);
    bus(1'b1, tccpo_pkg::OFS_COUNTER, 32'h0);
    repeat (64) @(posedge clk);
    chk(32'(pulse_out), 32'hc3a5);
    cap_a_in <= 1'b1;
    repeat (5) @(posedge clk);
    chk(32'(pulse_out), 32'h1111);
    cap_a_in <= 1'b0;
  endtask : t_pulse

  // Main sequence
  initial
  begin
    n_mismatch = 0;
    checked = 0;
    sys_rst = 1'b1;
    {avs_read, avs_write, cap_d_in, cap_a_in} = 4'h0;
    avs_address = 6'h0;
    avs_writedata = 32'h0;
    neighbour_count_pulse = 1'b0;
    neighbour_prescale_sel = 3'h0;
    neighbour_undivided = 1'b0;
    repeat (10) @(posedge clk);
    sys_rst <= 1'b0;
    t_reset_vals;
    t_compare;
    t_capture;
    t_overflow;
    t_underflow;
    t_pulse;
    tally_and_finish;
  end

  // Watchdog well beyond the expected run length
  initial
  begin
    repeat (20000) @(posedge clk);
    n_mismatch++;
    tally_and_finish;
  end
endmodule : tb
